// *** core/ufc_defines.vh ***
// Constants for the function-core control block: offsets, fields, resets.
// Assumes inclusion by bare name from core design files.
`ifndef UFC_DEFINES_VH
`define UFC_DEFINES_VH

`define UFC_SFR_ADDR 8'h96
`define UFC_SFR_DATA 8'h97
`define UFC_IDX_FUNC_ADDR 6'h00
`define UFC_IDX_POWER 6'h01
`define UFC_IDX_EP0_CTRL 6'h11

`define UFC_ADR_BUSY 7
`define UFC_ADR_AUTO_READ 6

`define UFC_PWR_ISO 7
`define UFC_PWR_INH 4
`define UFC_PWR_RST 3
`define UFC_PWR_RESUME 2
`define UFC_PWR_SUSP 1
`define UFC_PWR_SUSP_EN 0

`define UFC_E0_SETUP_END_ACK 7
`define UFC_E0_OUT_SVC 6
`define UFC_E0_STALL 5
`define UFC_E0_SETUP_END 4
`define UFC_E0_DEND 3
`define UFC_E0_STALL_SENT 2
`define UFC_E0_INRDY 1
`define UFC_E0_OUTRDY 0

`define UFC_RST_ADDR 8'h00
`define UFC_RST_FUNC_ADDR 8'h00
`define UFC_RST_POWER 8'h10
`define UFC_RST_EP0_CTRL 8'h00

// Indirect read latency in cycles, sized to the latency counter
`define UFC_READ_LAT 2'd2

`endif

// *** core/ufc_skid_buffer.v ***
// Two-entry valid/ready buffer for the indirect read data path.
// Assumes one synchronous active-low reset on the system clock.
`timescale 1ns/1ps
`default_nettype none

module ufc_skid_buffer #(
    parameter WIDTH = 8
) (
    input wire i_clk_sys,
    input wire i_resetn,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [WIDTH-1:0] i_in_data,
    output wire o_out_valid,
    input wire i_out_ready,
    output wire [WIDTH-1:0] o_out_data
);
    reg [WIDTH-1:0] mem_reg [0:1];
    reg rd_ptr_reg;
    reg wr_ptr_reg;
    reg [1:0] count_reg;
    wire push;
    wire pop;

    assign o_in_ready = (count_reg != 2'd2);
    assign o_out_valid = (count_reg != 2'd0);
    assign o_out_data = mem_reg[rd_ptr_reg];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            rd_ptr_reg <= 1'b0;
            wr_ptr_reg <= 1'b0;
            count_reg <= 2'd0;
            mem_reg[0] <= {WIDTH{1'b0}};
            mem_reg[1] <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                mem_reg[wr_ptr_reg] <= i_in_data;
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 2'd1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 2'd1;
            end
        end
    end
endmodule // ufc_skid_buffer

`default_nettype wire

// *** core/ufc_core_ctrl.v ***
// Function-core control: indirect register port, function address,
// power control and endpoint-zero handshakes.
// Assumes a byte-wide firmware register port and pulse-level bus events
// from a serial engine, all synchronous to i_clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "ufc_defines.vh"

// Contract
// - Writing busy one starts an indirect read at the index field; zero does nothing.
// - Busy clears once data is in the data register; data invalid while busy.
// - Auto-read on: each data read while busy is low starts the next read at same index.
// - Six-bit index field selects the core register for data reads and writes.
// - Function address register at index zero holds seven-bit device address.
// - New address used only after the current control transfer completes.
// - Pending bit sets on address write, clears when new address takes effect.
// - Iso update on: wait for frame start, earlier IN gets zero-length packet.
// - Inhibit set by reset, firmware only clears it; traffic ignored while set.
// - Writing bus-reset one forces controller reset; read shows bus reset state.
// - Resume one while suspended drives wakeup; writing zero interrupts, clears suspend.
// - Suspend state sets on entering suspend; clears on resume end or bus resume.
// - Suspend detect enable zero ignores bus suspend; one enters suspend.
// - Setup-end acknowledge write clears setup-end flag; reads zero.
// - Out-serviced write alone clears out-ready; reads zero.
// - Send stall ends transfer; cleared when stall sent, stall-sent set in the same cycle.
// - Setup-end flag sets when transaction ends before data-end written.
// - Firmware sets data-end with last handshake; device clears it itself.
// - In-ready cleared with interrupt when sent or overwritten by SETUP or OUT.
// - Endpoint-zero data packet received sets out-ready and raises interrupt.
module ufc_core_ctrl (
    input wire i_clk_sys,
    input wire i_resetn,
    input wire i_sfr_wr,
    input wire i_sfr_rd,
    input wire [7:0] i_sfr_addr,
    input wire [7:0] i_sfr_wdata,
    output reg [7:0] o_sfr_rdata,
    input wire i_bus_reset,
    input wire i_bus_suspend,
    input wire i_bus_resume,
    input wire i_sof,
    input wire i_in_token,
    input wire i_ep0_in_sent,
    input wire i_ep0_setup_rx,
    input wire i_ep0_out_rx,
    input wire i_ep0_stall_sent,
    input wire i_ctrl_xfer_end,
    input wire i_iso_armed,
    output wire [6:0] o_match_address,
    output wire o_traffic_enable,
    output wire o_force_core_reset,
    output wire o_resume_drive,
    output wire o_ep0_stall_req,
    output wire o_iso_send_zero_len,
    output wire o_iso_send_packet,
    output wire o_interrupt
);
    reg busy_reg;
    reg auto_read_enable_reg;
    reg [5:0] indirect_index_field_reg;
    reg [7:0] indirect_core_data_reg;
    reg [1:0] lat_cnt_reg;
    reg fetched_reg;
    reg [6:0] function_address_reg;
    reg [6:0] active_address_reg;
    reg addr_pending_reg;
    reg iso_update_on_frame_reg;
    reg controller_inhibit_reg;
    reg resume_reg;
    reg suspend_state_reg;
    reg suspend_detect_enable_reg;
    reg force_reset_reg;
    reg send_stall_reg;
    reg setup_end_flag_reg;
    reg data_end_a_reg;
    reg stall_sent_reg;
    reg in_ready_reg;
    reg out_ready_reg;
    reg sof_seen_reg;
    reg irq_reg;

    wire wr_adr = i_sfr_wr && (i_sfr_addr == `UFC_SFR_ADDR);
    wire wr_dat = i_sfr_wr && (i_sfr_addr == `UFC_SFR_DATA);
    wire rd_dat = i_sfr_rd && (i_sfr_addr == `UFC_SFR_DATA);
    wire wr_func_addr = wr_dat && (indirect_index_field_reg == `UFC_IDX_FUNC_ADDR);
    wire wr_power = wr_dat && (indirect_index_field_reg == `UFC_IDX_POWER);
    wire wr_e0 = wr_dat && (indirect_index_field_reg == `UFC_IDX_EP0_CTRL);
    // Inhibit masks every bus-side event except bus reset, which still reads through
    wire live = !controller_inhibit_reg;
    wire ev_sent = live && i_ep0_in_sent;
    wire ev_setup = live && i_ep0_setup_rx;
    wire ev_out = live && i_ep0_out_rx;
    wire ev_stall = live && i_ep0_stall_sent;
    wire ev_end = live && i_ctrl_xfer_end;

    // Read path: core register value captured into the buffer
    reg [7:0] core_val;
    always @* begin
        case (indirect_index_field_reg)
            `UFC_IDX_FUNC_ADDR: core_val = {addr_pending_reg, function_address_reg};
            `UFC_IDX_POWER: core_val = {iso_update_on_frame_reg, 2'b00,
                controller_inhibit_reg, i_bus_reset, resume_reg,
                suspend_state_reg, suspend_detect_enable_reg};
            `UFC_IDX_EP0_CTRL: core_val = {2'b00, send_stall_reg, setup_end_flag_reg,
                data_end_a_reg, stall_sent_reg, in_ready_reg, out_ready_reg};
            default: core_val = 8'h00;
        endcase
    end

    wire start_rd = (wr_adr && i_sfr_wdata[`UFC_ADR_BUSY]) ||
        (rd_dat && auto_read_enable_reg && !busy_reg);
    // One push per fetch; a second copy would clear busy of a later read
    wire fetch_done = busy_reg && !fetched_reg && (lat_cnt_reg == 2'd0);
    wire buf_in_ready;
    wire buf_out_valid;
    wire [7:0] buf_out_data;

    // Buffer drains every cycle it holds a word; the data register always takes it
    ufc_skid_buffer #(
        .WIDTH(8)
    ) u_buf (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_in_valid(fetch_done),
        .o_in_ready(buf_in_ready),
        .i_in_data(core_val),
        .o_out_valid(buf_out_valid),
        .i_out_ready(1'b1),
        .o_out_data(buf_out_data)
    );

    always @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            busy_reg <= 1'b0;
            fetched_reg <= 1'b0;
            lat_cnt_reg <= 2'd0;
            auto_read_enable_reg <= 1'b0;
            indirect_index_field_reg <= 6'h00;
            indirect_core_data_reg <= 8'h00;
        end else begin
            if (wr_adr) begin
                auto_read_enable_reg <= i_sfr_wdata[`UFC_ADR_AUTO_READ];
                indirect_index_field_reg <= i_sfr_wdata[5:0];
            end
            if (start_rd) begin
                busy_reg <= 1'b1;
                fetched_reg <= 1'b0;
                lat_cnt_reg <= `UFC_READ_LAT - 2'd1;
            end else begin
                if (fetch_done && buf_in_ready) begin
                    fetched_reg <= 1'b1;
                end else if (busy_reg && lat_cnt_reg != 2'd0) begin
                    lat_cnt_reg <= lat_cnt_reg - 2'd1;
                end
                // A fresh start keeps busy even if an older word lands now
                if (buf_out_valid) begin
                    busy_reg <= 1'b0;
                end
            end
            if (buf_out_valid) begin
                indirect_core_data_reg <= buf_out_data;
            end else if (wr_dat) begin
                indirect_core_data_reg <= i_sfr_wdata;
            end
        end
    end

    always @* begin
        if (i_sfr_addr == `UFC_SFR_ADDR) begin
            o_sfr_rdata = {busy_reg, auto_read_enable_reg, indirect_index_field_reg};
        end else if (i_sfr_addr == `UFC_SFR_DATA) begin
            o_sfr_rdata = indirect_core_data_reg;
        end else begin
            o_sfr_rdata = 8'h00;
        end
    end

    // Function address with deferred activation
    always @(posedge i_clk_sys) begin
        if (!i_resetn || force_reset_reg) begin
            function_address_reg <= 7'h00;
            active_address_reg <= 7'h00;
            addr_pending_reg <= 1'b0;
        end else begin
            if (wr_func_addr) begin
                function_address_reg <= i_sfr_wdata[6:0];
                addr_pending_reg <= 1'b1;
            end else if (addr_pending_reg && ev_end) begin
                active_address_reg <= function_address_reg;
                addr_pending_reg <= 1'b0;
            end
        end
    end
    assign o_match_address = active_address_reg;

    // Power control; a forced reset reinstates inhibit one cycle later
    always @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            force_reset_reg <= 1'b0;
            iso_update_on_frame_reg <= 1'b0;
            controller_inhibit_reg <= 1'b1;
            resume_reg <= 1'b0;
            suspend_state_reg <= 1'b0;
            suspend_detect_enable_reg <= 1'b0;
            sof_seen_reg <= 1'b0;
        end else begin
            force_reset_reg <= wr_power && i_sfr_wdata[`UFC_PWR_RST];
            if (force_reset_reg) begin
                controller_inhibit_reg <= 1'b1;
                iso_update_on_frame_reg <= 1'b0;
                resume_reg <= 1'b0;
                suspend_state_reg <= 1'b0;
                suspend_detect_enable_reg <= 1'b0;
                sof_seen_reg <= 1'b0;
            end else begin
                if (wr_power) begin
                    iso_update_on_frame_reg <= i_sfr_wdata[`UFC_PWR_ISO];
                    suspend_detect_enable_reg <= i_sfr_wdata[`UFC_PWR_SUSP_EN];
                    if (!i_sfr_wdata[`UFC_PWR_INH]) begin
                        controller_inhibit_reg <= 1'b0;
                    end
                    if (i_sfr_wdata[`UFC_PWR_RESUME] && suspend_state_reg) begin
                        resume_reg <= 1'b1;
                    end else if (!i_sfr_wdata[`UFC_PWR_RESUME]) begin
                        resume_reg <= 1'b0;
                    end
                end
                if (live && i_bus_suspend && suspend_detect_enable_reg) begin
                    suspend_state_reg <= 1'b1;
                end else if ((wr_power && resume_reg && !i_sfr_wdata[`UFC_PWR_RESUME]) ||
                    (live && i_bus_resume)) begin
                    suspend_state_reg <= 1'b0;
                end
                if (live && i_sof) begin
                    sof_seen_reg <= 1'b1;
                end else if (live && i_in_token && sof_seen_reg) begin
                    sof_seen_reg <= 1'b0;
                end
            end
        end
    end

    // Isochronous IN choice for the serial engine
    wire iso_ok = !iso_update_on_frame_reg || sof_seen_reg || (live && i_sof);
    assign o_iso_send_packet = live && i_in_token && i_iso_armed && iso_ok;
    assign o_iso_send_zero_len = live && i_in_token && i_iso_armed && !iso_ok;
    assign o_traffic_enable = live;
    assign o_force_core_reset = force_reset_reg;
    assign o_resume_drive = resume_reg;

    // Endpoint-zero handshakes; hardware sets beat firmware clears
    wire e0_b = wr_e0 ? 1'b1 : 1'b0;
    always @(posedge i_clk_sys) begin
        if (!i_resetn || force_reset_reg) begin
            send_stall_reg <= 1'b0;
            setup_end_flag_reg <= 1'b0;
            data_end_a_reg <= 1'b0;
            stall_sent_reg <= 1'b0;
            in_ready_reg <= 1'b0;
            out_ready_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= ev_sent && in_ready_reg || ((ev_setup || ev_out) && in_ready_reg) ||
                ev_setup || ev_out ||
                (wr_power && resume_reg && !i_sfr_wdata[`UFC_PWR_RESUME]);
            if (ev_stall && send_stall_reg) begin
                send_stall_reg <= 1'b0;
            end else if (e0_b && i_sfr_wdata[`UFC_E0_STALL]) begin
                send_stall_reg <= 1'b1;
            end
            if (ev_stall) begin
                stall_sent_reg <= 1'b1;
            end else if (e0_b && !i_sfr_wdata[`UFC_E0_STALL_SENT]) begin
                stall_sent_reg <= 1'b0;
            end
            if ((ev_end || ev_setup) && !data_end_a_reg &&
                !(e0_b && i_sfr_wdata[`UFC_E0_DEND])) begin
                setup_end_flag_reg <= 1'b1;
            end else if (e0_b && i_sfr_wdata[`UFC_E0_SETUP_END_ACK]) begin
                setup_end_flag_reg <= 1'b0;
            end
            if (ev_end) begin
                data_end_a_reg <= 1'b0;
            end else if (e0_b && i_sfr_wdata[`UFC_E0_DEND]) begin
                data_end_a_reg <= 1'b1;
            end
            if (ev_sent || ev_setup || ev_out) begin
                in_ready_reg <= 1'b0;
            end else if (e0_b && i_sfr_wdata[`UFC_E0_INRDY]) begin
                in_ready_reg <= 1'b1;
            end
            if (ev_setup || ev_out) begin
                out_ready_reg <= 1'b1;
            end else if (e0_b && i_sfr_wdata[`UFC_E0_OUT_SVC]) begin
                out_ready_reg <= 1'b0;
            end
        end
    end
    assign o_ep0_stall_req = send_stall_reg;
    assign o_interrupt = irq_reg;
endmodule // ufc_core_ctrl

`default_nettype wire

// *** dv/ufc_core_ctrl_assertions.sv ***
// Port-level assertions for the function-core control block.
// Assumes binding to ufc_core_ctrl, one clock, synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module ufc_core_ctrl_assertions (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_sfr_wr,
    input wire logic [7:0] i_sfr_addr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic i_ctrl_xfer_end,
    input wire logic i_in_token,
    input wire logic i_ep0_out_rx,
    input wire logic i_ep0_stall_sent,
    input wire logic [6:0] o_match_address,
    input wire logic o_traffic_enable,
    input wire logic o_force_core_reset,
    input wire logic o_ep0_stall_req,
    input wire logic o_iso_send_packet,
    input wire logic o_iso_send_zero_len,
    input wire logic o_interrupt
);
    logic [5:0] idx_reg;
    logic [6:0] fa_reg;
    logic pend_reg;
    wire logic core_wr;
    assign core_wr = i_sfr_wr && i_sfr_addr == 8'h97;
    // Shadow of the index and pending address, so the commit can be checked
    always @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            idx_reg <= 6'h00;
        end else if (i_sfr_wr && i_sfr_addr == 8'h96) begin
            idx_reg <= i_sfr_wdata[5:0];
        end
        if (!i_resetn || o_force_core_reset) begin
            pend_reg <= 1'b0;
        end else if (core_wr && idx_reg == 6'h00) begin
            pend_reg <= 1'b1;
        end else if (i_ctrl_xfer_end && o_traffic_enable) begin
            pend_reg <= 1'b0;
        end
        if (core_wr && idx_reg == 6'h00) begin
            fa_reg <= i_sfr_wdata[6:0];
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    sequence s_addr_commit;
        pend_reg && i_ctrl_xfer_end && o_traffic_enable;
    endsequence
    sequence s_stall_done;
        o_ep0_stall_req && i_ep0_stall_sent && o_traffic_enable;
    endsequence
    chk_force_reset_pulse: assert property (core_wr && idx_reg == 6'h01 && i_sfr_wdata[3]
        |=> o_force_core_reset ##1 !o_force_core_reset) else $error("forced reset pulse wrong");
    chk_iso_with_token: assert property ((o_iso_send_packet || o_iso_send_zero_len)
        |-> i_in_token && !(o_iso_send_packet && o_iso_send_zero_len)) else $error("iso reply");
    chk_inhibit_quiet: assert property (!o_traffic_enable |=> !o_interrupt)
        else $error("interrupt while inhibited");
    chk_address_hold: assert property (!$stable(o_match_address)
        |-> $past(i_ctrl_xfer_end) || $past(o_force_core_reset) || $past(o_force_core_reset, 2))
        else $error("match address changed early");
    chk_address_commit: assert property (s_addr_commit |=> o_match_address == fa_reg)
        else $error("new address not taken");
    chk_stall_request: assert property (core_wr && idx_reg == 6'h11 && i_sfr_wdata[5]
        |=> o_ep0_stall_req) else $error("stall request not raised");
    chk_stall_release: assert property (s_stall_done |=> !o_ep0_stall_req)
        else $error("stall request not cleared");
    chk_out_irq: assert property (i_ep0_out_rx && o_traffic_enable |=> o_interrupt)
        else $error("no interrupt on ep0 receive");
endmodule // ufc_core_ctrl_assertions

bind ufc_core_ctrl ufc_core_ctrl_assertions ufc_core_ctrl_assertions_inst (
    .i_clk_sys, .i_resetn, .i_sfr_wr, .i_sfr_addr, .i_sfr_wdata, .i_ctrl_xfer_end,
    .i_in_token, .i_ep0_out_rx, .i_ep0_stall_sent, .o_match_address, .o_traffic_enable,
    .o_force_core_reset, .o_ep0_stall_req, .o_iso_send_packet, .o_iso_send_zero_len,
    .o_interrupt
);
`default_nettype wire

// *** dv/ufc_host_model.sv ***
// Behavioural bus host: turns a command code into one-cycle bus event pulses.
// Assumes the command is set by non-blocking assignment at a rising edge.
`timescale 1ns/1ps
`default_nettype none
module ufc_host_model (
    input wire logic i_clk_sys,
    input wire logic [3:0] i_cmd,
    output var logic [8:0] o_event = 9'h000
);
    // Registered, so an event lands a full cycle after it is requested
    always @(posedge i_clk_sys) begin
        o_event <= (i_cmd == 4'h0) ? 9'h000 : 9'h001 << (i_cmd - 4'h1);
    end
endmodule // ufc_host_model
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench for the function-core control block.
// Assumes ufc_core_ctrl and the host model; core/ is on the include path.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic bus_rst = 1'b0;
    logic iso_armed = 1'b0;
    logic [3:0] cmd = 4'h0;
    logic [8:0] ev;
    logic [7:0] rdata;
    logic [6:0] match;
    logic ten, frst, resume, stall, iz, ip, iso_zero, iso_pkt, irq;
    logic [7:0] got;
    integer failures = 0;
    integer checked = 0;
    integer m_fa, seed;
    always #5 clk = ~clk;
    ufc_host_model ufc_host_model_inst (.i_clk_sys(clk), .i_cmd(cmd), .o_event(ev));
    ufc_core_ctrl ufc_core_ctrl_inst (
        .i_clk_sys(clk), .i_resetn(rstn), .i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_addr(addr),
        .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_bus_reset(bus_rst),
        .i_bus_suspend(ev[0]), .i_bus_resume(ev[1]), .i_sof(ev[2]), .i_in_token(ev[3]),
        .i_ep0_in_sent(ev[4]), .i_ep0_setup_rx(ev[5]), .i_ep0_out_rx(ev[6]),
        .i_ep0_stall_sent(ev[7]), .i_ctrl_xfer_end(ev[8]), .i_iso_armed(iso_armed),
        .o_match_address(match), .o_traffic_enable(ten), .o_force_core_reset(frst),
        .o_resume_drive(resume), .o_ep0_stall_req(stall), .o_iso_send_zero_len(iso_zero),
        .o_iso_send_packet(iso_pkt), .o_interrupt(irq)
    );
    task complete_run;
        if (failures == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task cmp(input logic [7:0] g, input logic [7:0] e);
        checked = checked + 1;
        if (g !== e) begin
            $display("ERROR time=%0t got=%h expected=%h", $time, g, e);
            failures = failures + 1;
        end
    endtask
    task wr_sfr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    // Waits for busy low, then looks at the data register
    task fetch(output logic [7:0] d);
        integer n;
        for (n = 0; n < 8 && rdata[7] !== 1'b0; n = n + 1) begin
            @(posedge clk);
            #1;
        end
        if (n == 8) begin
            failures = failures + 1;
            complete_run;
        end
        @(posedge clk);
        addr <= 8'h97;
        #1;
        d = rdata;
    endtask
    task rd_core(input logic [7:0] a, output logic [7:0] d);
        wr_sfr(8'h96, a);
        cmp(rdata & 8'h80, 8'h80);
        fetch(d);
    endtask
    // Data writes follow a finished fetch or another data write, so busy is already low
    task wr_core(input logic [5:0] i, input logic [7:0] d);
        wr_sfr(8'h96, {2'b00, i});
        wr_sfr(8'h97, d);
    endtask
    task chk(input logic [5:0] i, input logic [7:0] e);
        rd_core({2'b10, i}, got);
        cmp(got, e);
    endtask
    task host(input logic [3:0] c);
        @(posedge clk);
        cmd <= c;
        @(posedge clk);
        cmd <= 4'h0;
        #1;
        iz = iso_zero;
        ip = iso_pkt;
        @(posedge clk);
        #1;
    endtask
    initial begin
        seed = $urandom(32'h72fa);
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        addr <= 8'h96;
        #1;
        cmp(rdata, 8'h00);
        chk(6'h00, 8'h00);
        chk(6'h01, 8'h10);
        host(4'h7);
        chk(6'h11, 8'h00);
        wr_core(6'h01, 8'h11);
        chk(6'h01, 8'h11);
        cmp({7'h00, ten}, 8'h00);
        wr_core(6'h01, 8'h01);
        chk(6'h01, 8'h01);
        cmp({7'h00, ten}, 8'h01);
        wr_core(6'h01, 8'h11);
        chk(6'h01, 8'h01);
        wr_core(6'h3f, 8'h5a);
        chk(6'h3f, 8'h00);
        m_fa = 1 + $urandom % 127;
        wr_core(6'h00, m_fa[7:0]);
        chk(6'h00, 8'h80 | m_fa[7:0]);
        cmp({1'b0, match}, 8'h00);
        host(4'h9);
        cmp({1'b0, match}, m_fa[7:0]);
        chk(6'h00, m_fa[7:0]);
        chk(6'h11, 8'h10);
        wr_core(6'h11, 8'h80);
        host(4'h7);
        cmp({7'h00, irq}, 8'h01);
        chk(6'h11, 8'h01);
        wr_core(6'h11, 8'h40);
        chk(6'h11, 8'h00);
        host(4'h9);
        chk(6'h11, 8'h10);
        wr_core(6'h11, 8'h80);
        chk(6'h11, 8'h00);
        wr_core(6'h11, 8'h0a);
        chk(6'h11, 8'h0a);
        host(4'h5);
        cmp({7'h00, irq}, 8'h01);
        chk(6'h11, 8'h08);
        host(4'h9);
        chk(6'h11, 8'h00);
        wr_core(6'h11, 8'h02);
        host(4'h6);
        rd_core(8'h91, got);
        cmp(got & 8'h02, 8'h00);
        wr_core(6'h11, 8'hc0);
        wr_core(6'h11, 8'h20);
        cmp({7'h00, stall}, 8'h01);
        host(4'h8);
        chk(6'h11, 8'h04);
        wr_core(6'h11, 8'h00);
        chk(6'h11, 8'h00);
        host(4'h1);
        chk(6'h01, 8'h03);
        wr_core(6'h01, 8'h07);
        cmp({7'h00, resume}, 8'h01);
        // Resume is ended at once to keep the run short; the hold time is firmware's
        wr_core(6'h01, 8'h01);
        cmp({6'h00, resume, irq}, 8'h01);
        chk(6'h01, 8'h01);
        wr_core(6'h01, 8'h00);
        host(4'h1);
        chk(6'h01, 8'h00);
        wr_core(6'h01, 8'h01);
        host(4'h1);
        host(4'h2);
        chk(6'h01, 8'h01);
        @(posedge clk);
        iso_armed <= 1'b1;
        wr_core(6'h01, 8'h81);
        host(4'h4);
        cmp({6'h00, iz, ip}, 8'h02);
        host(4'h3);
        host(4'h4);
        cmp({6'h00, iz, ip}, 8'h01);
        wr_core(6'h01, 8'h01);
        host(4'h4);
        cmp({6'h00, iz, ip}, 8'h01);
        rd_core(8'hc1, got);
        cmp(got, 8'h01);
        @(posedge clk);
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= 8'h96;
        #1;
        cmp(rdata & 8'h80, 8'h80);
        fetch(got);
        cmp(got, 8'h01);
        @(posedge clk);
        bus_rst <= 1'b1;
        chk(6'h01, 8'h09);
        @(posedge clk);
        bus_rst <= 1'b0;
        wr_core(6'h01, 8'h08);
        cmp({7'h00, frst}, 8'h01);
        repeat (2) @(posedge clk);
        chk(6'h01, 8'h10);
        cmp({7'h00, ten}, 8'h00);
        complete_run;
    end
endmodule // tb
`default_nettype wire
